/* File: hdl/stos_pkg.sv */
// constants, encodings and register map of the torque-off supervisor
// assumes a single 100 MHz clock and an APB register port
package stos_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int FILT_TICKS = 2;
   localparam int RESP_MS = 15;
   localparam int DISC_OFF_MAX = 10;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DISC = 8'h04;
   localparam logic [7:0] ADDR_LOCK = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0c;
   localparam logic [7:0] ADDR_ALARM = 8'h10;
   localparam int CTRL_ALM_MODE = 0;
   localparam int CTRL_LEVEL = 1;
   localparam int CTRL_EXC_CLR = 2;
   localparam int CTRL_EXC_CON = 3;
   localparam int CTRL_EXC_STOP = 4;
   localparam logic [4:0] CTRL_RESET = 5'h10;
   localparam logic [6:0] DISC_RESET = 7'h00;
   localparam logic [6:0] LOCK_RESET = 7'h00;
   localparam logic [7:0] ALM_NONE = 8'h00;
   localparam logic [7:0] ALM_CHAN_OFF = 8'h68;
   localparam logic [7:0] ALM_DISC = 8'h53;
   typedef enum logic [1:0] {
      ST_TORQUE_OFF = 2'b00,
      ST_RETURN = 2'b01,
      ST_EXCITED = 2'b11
   } stos_state_type;
   typedef enum logic [2:0] {
      LAMP_OFF = 3'h0,
      LAMP_GREEN = 3'h1,
      LAMP_GREEN_BLINK = 3'h2,
      LAMP_RED_ONCE = 3'h3,
      LAMP_RED_TWICE = 3'h4
   } stos_lamp_type;
endpackage

/* File: hdl/stos_chan_if.sv */
// one safety channel between the supervisor and its input filter
// assumes tick is a one-cycle pulse once per millisecond
`timescale 1ns/10ps
interface stos_chan_if;
   logic tick;
   logic raw;
   logic act;
   modport filt (input tick, input raw, output act);
   modport sup (output tick, output raw, input act);
endinterface

/* File: hdl/stos_chan_filter.sv */
// synchroniser and off-pulse filter for one safety channel
// assumes raw is asynchronous to pclk and tick comes from the supervisor
`timescale 1ns/10ps
module stos_chan_filter
   import stos_pkg::*;
#(
   parameter int MS_CYCLES = TICK_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   stos_chan_if.filt ch
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic [1:0] ticks;
      logic act;
   } stos_filt_type;
   stos_filt_type q, d;
   int low_cnt;

   always_comb
   begin
      d = q;
      d.s1 = ch.raw;
      d.s2 = q.s1;
      if (q.s2)
      begin
         d.ticks = 2'h0;
         d.act = 1'b1;
      end
      else if (ch.tick && q.ticks != 2'(FILT_TICKS))
      begin
         // two tick edges inside one low stretch mean it lasted over 1 ms
         d.ticks = q.ticks + 2'h1;
         if (q.ticks == 2'(FILT_TICKS - 1))
            d.act = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '0;
      else
         q <= d;
   end

   assign ch.act = q.act;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         low_cnt <= 0;
      else if (q.s2)
         low_cnt <= 0;
      else if (low_cnt < MS_CYCLES * 4)
         low_cnt <= low_cnt + 1;
   end

   short_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(q.act) |-> low_cnt >= MS_CYCLES)
      else $error("channel dropped on an off pulse of 1 ms or less");
endmodule

/* File: hdl/stos_supervisor.sv */
// dual-channel torque-off supervisor with APB configuration registers
// assumes APB master on pclk; restore inputs already synchronous to pclk
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
module stos_supervisor
   import stos_pkg::*;
#(
   parameter int MS_CYCLES = TICK_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic safety_in_upper,
   input wire logic safety_in_lower,
   input wire logic excite_restore_in,
   input wire logic alarm_clear_in,
   input wire logic current_on_in,
   input wire logic stop_in,
   output logic upper_arm_en,
   output logic lower_arm_en,
   output logic failure_monitor_out,
   output logic ready,
   output logic pulse_accept_ok,
   output logic brake_release_out,
   output logic dyn_brake_out,
   output stos_lamp_type status_lamp,
   output logic [7:0] alarm_code
);
   localparam int PRE_W = $clog2(MS_CYCLES);

   typedef struct packed {
      stos_state_type state;
      logic [PRE_W-1:0] pre;
      logic tick;
      logic [6:0] lock_cnt;
      logic [6:0] disc_cnt;
      logic [3:0] prev_in;
      logic [4:0] ctrl;
      logic [6:0] disc_thr;
      logic [6:0] lock_ms;
      logic [7:0] alarm;
      logic upper_en;
      logic lower_en;
      logic fmon;
      logic run_out;
      logic dbrake;
      stos_lamp_type lamp;
      logic [31:0] rdata;
      logic rdy;
      logic err;
   } stos_sup_type;

   stos_sup_type q, d;
   logic [1:0] ch_act;
   logic act_u;
   logic act_l;
   logic [3:0] rise;
   logic lock_done;
   logic excite;
   logic access;
   logic mapped;

   generate
      for (genvar i = 0; i < 2; i++)
      begin : gen_ch
         stos_chan_if ch_if ();
         assign ch_if.tick = q.tick;
         assign ch_if.raw = (i == 0) ? safety_in_upper : safety_in_lower;
         assign ch_act[i] = ch_if.act;
         stos_chan_filter #(.MS_CYCLES(MS_CYCLES)) u_filt (
            .pclk(pclk),
            .presetn(presetn),
            .ch(ch_if.filt)
         );
      end
   endgenerate

   assign act_u = ch_act[0];
   assign act_l = ch_act[1];

   always_comb
   begin
      d = q;
      // millisecond prescaler
      d.tick = 1'b0;
      if (q.pre == PRE_W'(MS_CYCLES - 1))
      begin
         d.pre = '0;
         d.tick = 1'b1;
      end
      else
         d.pre = q.pre + 1'b1;

      // bit order: restore, alarm clear, current on, stop
      d.prev_in = {excite_restore_in, alarm_clear_in, current_on_in, stop_in};
      rise = d.prev_in & ~q.prev_in;

      // skew between channels, counted in ms while exactly one is off
      if (act_u == act_l)
         d.disc_cnt = 7'h00;
      else if (q.tick && q.disc_cnt != 7'h7f)
         d.disc_cnt = q.disc_cnt + 7'h01;

      // alarms; the skew alarm outranks the channel-off alarm
      if (act_u && act_l && rise[2])
         d.alarm = ALM_NONE;
      if (q.disc_thr > 7'(DISC_OFF_MAX) && q.disc_cnt > q.disc_thr)
         d.alarm = ALM_DISC;
      else if (q.ctrl[CTRL_ALM_MODE] && !(act_u && act_l) && q.alarm == ALM_NONE)
         d.alarm = ALM_CHAN_OFF;

      // lockout after both channels come back
      lock_done = q.lock_cnt >= q.lock_ms;
      if (q.state != ST_RETURN)
         d.lock_cnt = 7'h00;
      else if (q.tick && q.lock_cnt != 7'h7f)
         d.lock_cnt = q.lock_cnt + 7'h01;

      excite = 1'b0;
      if (q.ctrl[CTRL_LEVEL])
         excite = excite_restore_in && lock_done;
      else
         excite = rise[3] && lock_done;
      if (rise[2] && (q.ctrl[CTRL_ALM_MODE] || q.ctrl[CTRL_EXC_CLR]))
         excite = 1'b1;
      if (rise[1] && q.ctrl[CTRL_EXC_CON])
         excite = 1'b1;
      if (rise[0] && q.ctrl[CTRL_EXC_STOP])
         excite = 1'b1;

      case (q.state)
         ST_EXCITED:
            if (!act_u || !act_l)
               d.state = ST_TORQUE_OFF;
         ST_TORQUE_OFF:
            if (act_u && act_l)
               d.state = ST_RETURN;
         ST_RETURN:
            if (!act_u || !act_l)
               d.state = ST_TORQUE_OFF;
            else if (excite && d.alarm == ALM_NONE)
               d.state = ST_EXCITED;
         default:
            d.state = ST_TORQUE_OFF;
      endcase

      // outputs follow the next state so they leave with it
      d.upper_en = (d.state == ST_EXCITED) && act_u;
      d.lower_en = (d.state == ST_EXCITED) && act_l;
      d.fmon = !act_u && !act_l;
      d.run_out = d.state == ST_EXCITED;
      d.dbrake = d.state == ST_RETURN;
      if (d.alarm == ALM_DISC)
         d.lamp = LAMP_RED_TWICE;
      else if (d.alarm == ALM_CHAN_OFF)
         d.lamp = LAMP_RED_ONCE;
      else if (d.state == ST_EXCITED)
         d.lamp = LAMP_GREEN;
      else
         d.lamp = LAMP_GREEN_BLINK;

      // APB slave: ready comes one cycle into the access phase
      access = psel && penable && !q.rdy;
      mapped = paddr == ADDR_CTRL || paddr == ADDR_DISC || paddr == ADDR_LOCK
         || paddr == ADDR_STAT || paddr == ADDR_ALARM;
      d.rdy = access;
      d.err = access && !mapped;
      d.rdata = 32'h0000_0000;
      if (access && !pwrite)
      begin
         case (paddr)
            ADDR_CTRL: d.rdata = {27'h0, q.ctrl};
            ADDR_DISC: d.rdata = {25'h0, q.disc_thr};
            ADDR_LOCK: d.rdata = {25'h0, q.lock_ms};
            ADDR_STAT: d.rdata = {26'h0, lock_done, q.fmon, act_l, act_u, q.state};
            ADDR_ALARM: d.rdata = {24'h0, q.alarm};
            default: d.rdata = 32'h0000_0000;
         endcase
      end
      if (psel && penable && q.rdy && pwrite)
      begin
         case (paddr)
            ADDR_CTRL: d.ctrl = pwdata[4:0];
            ADDR_DISC: d.disc_thr = pwdata[6:0];
            ADDR_LOCK: d.lock_ms = pwdata[6:0];
            default: d.ctrl = q.ctrl;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '0;
         q.state <= ST_TORQUE_OFF;
         q.ctrl <= CTRL_RESET;
         q.disc_thr <= DISC_RESET;
         q.lock_ms <= LOCK_RESET;
         q.alarm <= ALM_NONE;
         q.lamp <= LAMP_GREEN_BLINK;
      end
      else
         q <= d;
   end

   assign prdata = q.rdata;
   assign pready = q.rdy;
   assign pslverr = q.err;
   assign upper_arm_en = q.upper_en;
   assign lower_arm_en = q.lower_en;
   assign failure_monitor_out = q.fmon;
   assign ready = q.run_out;
   assign pulse_accept_ok = q.run_out;
   assign brake_release_out = q.run_out;
   assign dyn_brake_out = q.dbrake;
   assign status_lamp = q.lamp;
   assign alarm_code = q.alarm;

   // checks
   int off_cnt;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         off_cnt <= 0;
      else if (safety_in_upper && safety_in_lower)
         off_cnt <= 0;
      else if (off_cnt < MS_CYCLES * RESP_MS)
         off_cnt <= off_cnt + 1;
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   upper_cut_a: assert property (!act_u |=> !upper_arm_en)
      else $error("upper arm driven with upper channel off");
   lower_cut_a: assert property (!act_l |=> !lower_arm_en)
      else $error("lower arm driven with lower channel off");
   monitor_pair_a: assert property (presetn |=> failure_monitor_out == $past(!act_u && !act_l))
      else $error("failure monitor disagrees with channel pair");
   power_cut_a: assert property (off_cnt >= MS_CYCLES * RESP_MS |-> !upper_arm_en || !lower_arm_en)
      else $error("power not cut within response time");
   off_outputs_a: assert property (q.state != ST_EXCITED |-> !ready && !pulse_accept_ok
      && !brake_release_out && status_lamp != LAMP_GREEN)
      else $error("ready, pulse or brake active in torque-off");
   chan_alarm_a: assert property (q.ctrl[CTRL_ALM_MODE] && !(act_u && act_l) && q.alarm == ALM_NONE
      |=> alarm_code == ALM_CHAN_OFF || alarm_code == ALM_DISC ##0 status_lamp != LAMP_GREEN)
      else $error("channel-off alarm missing");
   skew_alarm_a: assert property (q.disc_thr > 7'(DISC_OFF_MAX) && q.disc_cnt > q.disc_thr
      |=> alarm_code == ALM_DISC && status_lamp == LAMP_RED_TWICE)
      else $error("channel skew alarm missing");
   return_hold_a: assert property (q.state == ST_RETURN |-> dyn_brake_out && !failure_monitor_out
      && !upper_arm_en && !lower_arm_en)
      else $error("return state not in dynamic brake");
   restore_edge_a: assert property (q.state == ST_RETURN && act_u && act_l && rise[3]
      && lock_done && !q.ctrl[CTRL_LEVEL] && d.alarm == ALM_NONE
      |=> q.state == ST_EXCITED ##1 status_lamp == LAMP_GREEN)
      else $error("restore edge did not excite");
   lockout_a: assert property (q.state == ST_RETURN && !lock_done && rise[2:0] == 3'h0
      |=> q.state != ST_EXCITED)
      else $error("excited during lockout");
   level_mode_a: assert property (q.state == ST_RETURN && act_u && act_l && q.ctrl[CTRL_LEVEL]
      && excite_restore_in && lock_done && d.alarm == ALM_NONE |=> q.state == ST_EXCITED)
      else $error("level restore did not excite");

   excite_c: cover property (q.state == ST_RETURN ##1 q.state == ST_EXCITED);
   skew_c: cover property (alarm_code == ALM_DISC);
   chan_off_c: cover property (alarm_code == ALM_CHAN_OFF);
   stop_exc_c: cover property (rise[0] && q.state == ST_RETURN ##1 q.state == ST_EXCITED);
endmodule

/* File: dv/stos_safety_model.sv */
// behavioural model of the external safety module feeding both channels
// assumes the bench drives door_open, pulse_req and stuck_upper after pclk edges
`timescale 1ns/10ps
module stos_safety_model
#(
   parameter int MS_CYCLES = 20
)
(
   input wire logic pclk,
   input wire logic door_open,
   input wire logic pulse_req,
   input wire logic stuck_upper,
   input wire logic failure_monitor_out,
   output logic safety_in_upper,
   output logic safety_in_lower
);
   logic on_q = 1'b0;
   int cnt_q = 0;

   // outputs re-enabled only after a reset that the monitor feedback allows
   always_ff @(posedge pclk)
   begin
      if (door_open)
         on_q <= 1'b0;
      else if (failure_monitor_out)
         on_q <= 1'b1;
      if (pulse_req && cnt_q == 0)
         cnt_q <= MS_CYCLES;
      else if (cnt_q != 0)
         cnt_q <= cnt_q - 1;
   end

   // stuck_upper models a welded contact on the upper channel
   assign safety_in_upper = stuck_upper | (on_q & (cnt_q == 0));
   assign safety_in_lower = on_q & (cnt_q == 0);
endmodule

/* File: dv/tb.sv */
// self-checking bench of the torque-off supervisor
// assumes the safety module model and a 20-cycle millisecond
`timescale 1ns/10ps
module tb
   import stos_pkg::*;
;
   localparam int MS = 20;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, safety_in_upper, safety_in_lower;
   logic [3:0] src = 4'h0;
   logic door_open = 1, pulse_req = 0, stuck_upper = 0;
   logic upper_arm_en, lower_arm_en, failure_monitor_out, ready;
   logic pulse_accept_ok, brake_release_out, dyn_brake_out;
   stos_lamp_type status_lamp;
   logic [7:0] alarm_code;
   int err_total = 0;
   int comparisons = 0;

   always #5 pclk = ~pclk;

   stos_supervisor #(.MS_CYCLES(MS)) u_stos_supervisor (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .safety_in_upper(safety_in_upper),
      .safety_in_lower(safety_in_lower), .excite_restore_in(src[0]), .alarm_clear_in(src[1]),
      .current_on_in(src[2]), .stop_in(src[3]), .upper_arm_en(upper_arm_en),
      .lower_arm_en(lower_arm_en), .failure_monitor_out(failure_monitor_out), .ready(ready),
      .pulse_accept_ok(pulse_accept_ok), .brake_release_out(brake_release_out),
      .dyn_brake_out(dyn_brake_out), .status_lamp(status_lamp), .alarm_code(alarm_code));

   stos_safety_model #(.MS_CYCLES(MS)) u_stos_safety_model (.pclk(pclk),
      .door_open(door_open), .pulse_req(pulse_req), .stuck_upper(stuck_upper),
      .failure_monitor_out(failure_monitor_out), .safety_in_upper(safety_in_upper),
      .safety_in_lower(safety_in_lower));

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // waits for pready without a limit of its own; the watchdog ends a hang
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      // idle cycle so a following call never re-raises psel in the same step
      @(posedge pclk);
   endtask

   task automatic wait_ms(input int n);
      repeat (n * MS) @(posedge pclk);
   endtask

   task automatic kick(input int b);
      src[b] <= 1;
      repeat (3) @(posedge pclk);
      src[b] <= 0;
      repeat (3) @(posedge pclk);
   endtask

   task automatic run_chk(input logic on);
      chk("drive", {27'h0, upper_arm_en, lower_arm_en, ready, pulse_accept_ok,
         brake_release_out}, on ? 32'h1f : 32'h0);
   endtask

   task automatic lamp_chk(input stos_lamp_type l);
      chk("lamp", {29'h0, status_lamp}, {29'h0, l});
   endtask

   task automatic go_off;
      door_open <= 1;
      wait_ms(RESP_MS);
   endtask

   task automatic go_on;
      door_open <= 0;
      wait_ms(1);
   endtask

   task automatic t_up;
      apb(0, ADDR_CTRL, 0);
      chk("ctrl", rd, {27'h0, CTRL_RESET});
      apb(0, ADDR_DISC, 0);
      chk("disc", rd, 32'h0);
      apb(0, 8'h14, 0);
      chk("unmapped", {er, rd[30:0]}, 32'h80000000);
      chk("fmon", failure_monitor_out, 1);
      go_on;
      chk("fmon", failure_monitor_out, 0);
      chk("dbrake", dyn_brake_out, 1);
      lamp_chk(LAMP_GREEN_BLINK);
      run_chk(0);
      kick(0);
      run_chk(1);
      lamp_chk(LAMP_GREEN);
      apb(0, ADDR_STAT, 0);
      chk("stat", rd, 32'h0000_002f);
   endtask

   task automatic t_pulse;
      pulse_req <= 1;
      @(posedge pclk);
      pulse_req <= 0;
      wait_ms(3);
      run_chk(1);
   endtask

   task automatic t_lock;
      go_off;
      run_chk(0);
      chk("fmon", failure_monitor_out, 1);
      lamp_chk(LAMP_GREEN_BLINK);
      chk("alarm", alarm_code, 0);
      apb(1, ADDR_LOCK, 32'h5);
      go_on;
      kick(0);
      run_chk(0);
      wait_ms(6);
      kick(0);
      run_chk(1);
   endtask

   task automatic t_level;
      apb(1, ADDR_CTRL, 32'h12);
      go_off;
      go_on;
      src[0] <= 1;
      wait_ms(7);
      run_chk(1);
      src[0] <= 0;
      @(posedge pclk);
   endtask

   task automatic t_alarm;
      apb(1, ADDR_CTRL, 32'h15);
      go_off;
      chk("alarm", alarm_code, {24'h0, ALM_CHAN_OFF});
      lamp_chk(LAMP_RED_ONCE);
      go_on;
      run_chk(0);
      kick(1);
      run_chk(1);
      chk("alarm", alarm_code, 0);
   endtask

   task automatic t_skew;
      apb(1, ADDR_CTRL, {27'h0, CTRL_RESET});
      apb(1, ADDR_DISC, 32'd12);
      stuck_upper <= 1;
      go_off;
      wait_ms(3);
      chk("alarm", alarm_code, {24'h0, ALM_DISC});
      lamp_chk(LAMP_RED_TWICE);
      chk("fmon", failure_monitor_out, 0);
      chk("lower", lower_arm_en, 0);
      apb(0, ADDR_ALARM, 0);
      chk("alarm_reg", rd, {24'h0, ALM_DISC});
      door_open <= 0;
      wait_ms(2);
      chk("held_off", safety_in_lower, 0);
      stuck_upper <= 0;
      wait_ms(4);
      kick(1);
      kick(3);
      run_chk(1);
      chk("alarm", alarm_code, 0);
   endtask

   // besides the restore edge only current-on may excite: stop and alarm clear must be ignored
   task automatic t_con;
      apb(1, ADDR_CTRL, 32'h0000_0008);
      go_off;
      go_on;
      kick(3);
      kick(1);
      run_chk(0);
      kick(2);
      run_chk(1);
      lamp_chk(LAMP_GREEN);
   endtask

   initial
   begin
      repeat (4) @(posedge pclk);
      run_chk(0);
      lamp_chk(LAMP_GREEN_BLINK);
      presetn <= 1;
      wait_ms(1);
      t_up;
      t_pulse;
      t_lock;
      t_level;
      t_alarm;
      t_skew;
      t_con;
      finish_test;
   end

   initial
   begin
      repeat (6000) @(posedge pclk);
      err_total++;
      finish_test;
   end
endmodule
